/* include/dfx_pkg.sv */
// dfx_pkg: constants and carrier types for the data flash and xram window controller
package dfx_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned ERASE_TIME_US   = 5_000;
    localparam int unsigned PROG_TIME_US    = 50;
    localparam int unsigned ERASE_CYCLES    = (ERASE_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned PROG_CYCLES     = (PROG_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned TMR_W           = 16;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int unsigned FL_AW           = 11;
    localparam int unsigned FL_DEPTH        = 2048;
    localparam int unsigned PAGE_AW         = 6;
    localparam int unsigned PAGE_NUM_W      = 5;
    localparam logic [15:0] FL_TOP          = 16'h07FF;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

    // ************************************************************
    // register offsets (byte-wide registers on the plain port)
    // ************************************************************
    localparam logic [3:0] OFS_CTRL         = 4'h0;
    localparam logic [3:0] OFS_ADDR_HI      = 4'h1;
    localparam logic [3:0] OFS_ADDR_LO      = 4'h2;
    localparam logic [3:0] OFS_WDATA        = 4'h3;
    localparam logic [3:0] OFS_PMC          = 4'h4;
    localparam logic [3:0] OFS_IRQ_EN       = 4'h5;
    localparam logic [3:0] OFS_PAGE_HI      = 4'h6;
    localparam logic [3:0] OFS_STATUS       = 4'h7;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned CTRL_ERASE_BIT  = 7;
    localparam int unsigned CTRL_PROG_BIT   = 6;
    localparam int unsigned CTRL_WIN_BIT    = 5;
    localparam int unsigned CTRL_DONE_BIT   = 0;
    localparam int unsigned PMC_XRAM_BIT    = 0;
    localparam int unsigned IRQ_EN_BIT      = 5;
    localparam int unsigned STS_BUSY_BIT    = 0;
    localparam int unsigned STS_OSC_BIT     = 1;
    localparam int unsigned STS_IRQ_BIT     = 2;

    typedef enum logic [1:0] {
        DFX_DST_NONE,
        DFX_DST_EXT,
        DFX_DST_XRAM,
        DFX_DST_FLASH
    } dfx_dst_e;

    // one external-move request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        via_data_pointer_16bit;
        logic [15:0] data_pointer_16bit;
        logic [7:0]  index;
        logic [7:0]  wdata;
    } dfx_external_move_instruction_s;

endpackage

/* rtl/dfx_flash_array.sv */
// dfx_flash_array: flip-flop model of the 2 KB data flash with page erase and byte program
`timescale 1ns/10ps
module dfx_flash_array #(
    parameter int unsigned AW    = dfx_pkg::FL_AW,
    parameter int unsigned DEPTH = dfx_pkg::FL_DEPTH
) (
    input  wire logic          mclk,       // system clock
    input  wire logic          rst,        // synchronous reset, active high
    input  wire logic [AW-1:0] raddr,      // read address
    output logic      [7:0]    rdata,      // registered read data
    input  wire logic          erase_stb,  // erase the page holding waddr
    input  wire logic          prog_stb,   // program one byte at waddr
    input  wire logic [AW-1:0] waddr,      // target address
    input  wire logic [7:0]    wdata       // byte to program
);

    logic [7:0] mem_q [DEPTH];

    // programming can only clear bits, as a real cell does
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_cell
            localparam logic [AW-1:0] CELL_ADDR = AW'(gi);
            wire logic in_page = (waddr[AW-1:dfx_pkg::PAGE_AW] ==
                                  CELL_ADDR[AW-1:dfx_pkg::PAGE_AW]);
            wire logic is_byte = (waddr == CELL_ADDR);
            always_ff @(posedge mclk) begin
                if (erase_stb && in_page) begin
                    mem_q[gi] <= dfx_pkg::ERASED_BYTE;
                end else if (prog_stb && is_byte) begin
                    mem_q[gi] <= mem_q[gi] & wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem_q[raddr];
        end
    end

endmodule

/* rtl/dfx_ctrl.sv */
// dfx_ctrl: data flash controller and external-move window decoder
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
module dfx_ctrl #(
    parameter int unsigned ERASE_CYC = dfx_pkg::ERASE_CYCLES,
    parameter int unsigned PROG_CYC  = dfx_pkg::PROG_CYCLES
) (
    input  wire logic              mclk,         // system clock, 10 MHz
    input  wire logic              rst,          // synchronous reset, active high
    input  wire logic [3:0]        reg_addr,     // register address
    input  wire logic [7:0]        reg_wdata,    // register write data
    input  wire logic              reg_wr,       // register write strobe
    input  wire logic              reg_rd,       // register read strobe
    output logic      [7:0]        reg_rdata,    // read data, cycle after strobe
    input  wire dfx_pkg::dfx_external_move_instruction_s external_move_instruction,        // external-move request
    output dfx_pkg::dfx_dst_e      external_move_instruction_dst,     // routing of the current move
    output logic      [15:0]       external_move_instruction_addr,    // resolved move address
    output logic                   ext_rd,       // external bus read
    output logic                   ext_wr,       // external bus write
    output logic                   xram_rd,      // auxiliary sram read
    output logic                   xram_wr,      // auxiliary sram write
    output logic      [7:0]        flash_rdata,  // flash read data, cycle after move
    output logic                   flash_rvalid, // flash read data valid
    input  wire logic              lock_n,       // security lock, low locks out programmer
    input  wire logic              prg_req,      // external programmer access request
    output logic                   prg_grant,    // external programmer access allowed
    input  wire logic              global_ie,    // core global interrupt enable
    input  wire logic              idle,         // core in idle mode
    output logic                   irq,          // completion interrupt request
    output logic                   wake,         // idle wake-up pulse
    output logic                   osc_en,       // flash timing oscillator enable
    output logic                   busy,         // erase or program running
    output logic                   cpu_stall     // always low; core never stalls
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        DFX_IDLE,
        DFX_ERASE,
        DFX_PROG
    } dfx_state_e;

    dfx_state_e  st_q, st_d;
    logic        win_q, xram_en_q, done_q, irq_en_q;
    logic [7:0]  ahi_q, alo_q, wdat_q, page_hi_q;
    logic [dfx_pkg::TMR_W-1:0] tmr_q;
    logic        rvalid_q;
    logic [7:0]  reg_rdata_q;

    // ************************************************************
    // decoding
    // ************************************************************
    function automatic logic wr_at(input logic [3:0] ofs);
        return reg_wr && (reg_addr == ofs);
    endfunction

    wire logic [15:0] op_addr   = {ahi_q, alo_q};
    wire logic        op_in_rng = (op_addr <= dfx_pkg::FL_TOP);
    wire logic        is_idle   = (st_q == DFX_IDLE);
    wire logic        ctl_wr    = wr_at(dfx_pkg::OFS_CTRL);
    wire logic        req_er    = ctl_wr && reg_wdata[dfx_pkg::CTRL_ERASE_BIT]
                                  && reg_wdata[dfx_pkg::CTRL_WIN_BIT];
    wire logic        req_pg    = ctl_wr && reg_wdata[dfx_pkg::CTRL_PROG_BIT]
                                  && reg_wdata[dfx_pkg::CTRL_WIN_BIT]
                                  && !reg_wdata[dfx_pkg::CTRL_ERASE_BIT];
    // a request only starts from idle with done clear and in range
    wire logic        can_start = is_idle && !done_q && op_in_rng;
    wire logic        start_er  = req_er && can_start;
    wire logic        start_pg  = req_pg && can_start;
    wire logic        tmr_end   = !is_idle && (tmr_q == '0);
    wire logic        fin_er    = tmr_end && (st_q == DFX_ERASE);
    wire logic        fin_pg    = tmr_end && (st_q == DFX_PROG);

    // ************************************************************
    // operation sequencer
    // ************************************************************
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            DFX_IDLE: begin
                if (start_er) begin
                    st_d = DFX_ERASE;
                end else if (start_pg) begin
                    st_d = DFX_PROG;
                end
            end
            DFX_ERASE: begin
                if (tmr_end) begin
                    st_d = DFX_IDLE;
                end
            end
            DFX_PROG: begin
                if (tmr_end) begin
                    st_d = DFX_IDLE;
                end
            end
            default: st_d = DFX_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= DFX_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // the operation is committed at the array when the timer ends
    always_ff @(posedge mclk) begin
        if (rst) begin
            tmr_q <= '0;
        end else if (start_er) begin
            tmr_q <= dfx_pkg::TMR_W'(ERASE_CYC - 1);
        end else if (start_pg) begin
            tmr_q <= dfx_pkg::TMR_W'(PROG_CYC - 1);
        end else if (!is_idle && tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // done flag: hardware set wins over a software clear in the same cycle
    wire logic done_clr = ctl_wr && !reg_wdata[dfx_pkg::CTRL_DONE_BIT];

    always_ff @(posedge mclk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (tmr_end) begin
            done_q <= 1'b1;
        end else if (done_clr) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            win_q     <= 1'b0;
            xram_en_q <= 1'b0;
            irq_en_q  <= 1'b0;
            page_hi_q <= 8'h00;
        end else begin
            if (ctl_wr) begin
                win_q <= reg_wdata[dfx_pkg::CTRL_WIN_BIT];
            end
            if (wr_at(dfx_pkg::OFS_PMC)) begin
                xram_en_q <= reg_wdata[dfx_pkg::PMC_XRAM_BIT];
            end
            if (wr_at(dfx_pkg::OFS_IRQ_EN)) begin
                irq_en_q <= reg_wdata[dfx_pkg::IRQ_EN_BIT];
            end
            if (wr_at(dfx_pkg::OFS_PAGE_HI)) begin
                page_hi_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ahi_q  <= 8'h00;
            alo_q  <= 8'h00;
            wdat_q <= 8'h00;
        end else begin
            if (wr_at(dfx_pkg::OFS_ADDR_HI) && is_idle) begin
                ahi_q <= reg_wdata;
            end
            if (wr_at(dfx_pkg::OFS_ADDR_LO) && is_idle) begin
                alo_q <= reg_wdata;
            end
            if (wr_at(dfx_pkg::OFS_WDATA) && (st_q != DFX_PROG)) begin
                wdat_q <= reg_wdata;
            end
        end
    end

    // request bits read back as the running operation, cleared on finish
    wire logic [7:0] ctrl_rd =
        ({7'h00, st_q == DFX_ERASE} << dfx_pkg::CTRL_ERASE_BIT) |
        ({7'h00, st_q == DFX_PROG}  << dfx_pkg::CTRL_PROG_BIT)  |
        ({7'h00, win_q}             << dfx_pkg::CTRL_WIN_BIT)   |
        ({7'h00, done_q}            << dfx_pkg::CTRL_DONE_BIT);
    wire logic [7:0] sts_rd =
        ({7'h00, !is_idle} << dfx_pkg::STS_BUSY_BIT) |
        ({7'h00, osc_en}   << dfx_pkg::STS_OSC_BIT)  |
        ({7'h00, irq}      << dfx_pkg::STS_IRQ_BIT);

    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            dfx_pkg::OFS_CTRL:    rd_mux = ctrl_rd;
            dfx_pkg::OFS_ADDR_HI: rd_mux = ahi_q;
            dfx_pkg::OFS_ADDR_LO: rd_mux = alo_q;
            dfx_pkg::OFS_WDATA:   rd_mux = wdat_q;
            dfx_pkg::OFS_PMC:     rd_mux = {7'h00, xram_en_q} << dfx_pkg::PMC_XRAM_BIT;
            dfx_pkg::OFS_IRQ_EN:  rd_mux = {7'h00, irq_en_q} << dfx_pkg::IRQ_EN_BIT;
            dfx_pkg::OFS_PAGE_HI: rd_mux = page_hi_q;
            dfx_pkg::OFS_STATUS:  rd_mux = sts_rd;
            default:              rd_mux = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_q <= 8'h00;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // ************************************************************
    // external-move window
    // ************************************************************
    wire logic [15:0] mv_addr  = external_move_instruction.via_data_pointer_16bit ? external_move_instruction.data_pointer_16bit : {page_hi_q, external_move_instruction.index};
    wire logic        mv_low   = (mv_addr <= dfx_pkg::FL_TOP);

    dfx_pkg::dfx_dst_e dst;
    always_comb begin
        dst = dfx_pkg::DFX_DST_NONE;
        if (!external_move_instruction.valid) begin
            dst = dfx_pkg::DFX_DST_NONE;
        end else if (win_q) begin
            if (!external_move_instruction.via_data_pointer_16bit) begin
                // index moves stay inside the window; writes are dropped
                dst = external_move_instruction.write ? dfx_pkg::DFX_DST_NONE : dfx_pkg::DFX_DST_FLASH;
            end else if (!mv_low) begin
                dst = dfx_pkg::DFX_DST_EXT;
            end else begin
                dst = external_move_instruction.write ? dfx_pkg::DFX_DST_NONE : dfx_pkg::DFX_DST_FLASH;
            end
        end else if (xram_en_q && mv_low) begin
            dst = dfx_pkg::DFX_DST_XRAM;
        end else begin
            dst = dfx_pkg::DFX_DST_EXT;
        end
    end

    assign external_move_instruction_dst  = dst;
    assign external_move_instruction_addr = mv_addr;
    assign ext_rd    = (dst == dfx_pkg::DFX_DST_EXT)  && !external_move_instruction.write;
    assign ext_wr    = (dst == dfx_pkg::DFX_DST_EXT)  && external_move_instruction.write;
    assign xram_rd   = (dst == dfx_pkg::DFX_DST_XRAM) && !external_move_instruction.write;
    assign xram_wr   = (dst == dfx_pkg::DFX_DST_XRAM) && external_move_instruction.write;

    // flash_rvalid stays low for moves made while the array is busy
    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= (dst == dfx_pkg::DFX_DST_FLASH) && is_idle;
        end
    end
    assign flash_rvalid = rvalid_q;

    dfx_flash_array u_array (
        .mclk      (mclk),
        .rst       (rst),
        .raddr     (mv_addr[dfx_pkg::FL_AW-1:0]),
        .rdata     (flash_rdata),
        .erase_stb (fin_er),
        .prog_stb  (fin_pg),
        .waddr     (op_addr[dfx_pkg::FL_AW-1:0]),
        .wdata     (wdat_q)
    );

    // ************************************************************
    // system outputs
    // ************************************************************
    assign osc_en    = !is_idle;
    assign busy      = !is_idle;
    assign cpu_stall = 1'b0;
    assign irq       = done_q && irq_en_q;
    assign wake      = tmr_end && irq_en_q && global_ie && idle;
    assign prg_grant = prg_req && lock_n;

    // ************************************************************
    // checks
    // ************************************************************
    a_erase_len: assert property (@(posedge mclk) disable iff (rst)
        $rose(st_q == DFX_ERASE) |-> (st_q == DFX_ERASE) [*8])
        else $error("erase ended too early");
    a_osc_gate: assert property (@(posedge mclk) disable iff (rst)
        osc_en == (st_q != DFX_IDLE))
        else $error("oscillator enable wrong");
    a_done_set: assert property (@(posedge mclk) disable iff (rst)
        tmr_end |=> done_q && (st_q == DFX_IDLE))
        else $error("done not set at finish");
    a_no_start_done: assert property (@(posedge mclk) disable iff (rst)
        (is_idle && done_q) |=> is_idle)
        else $error("operation started while done set");
    a_range_block: assert property (@(posedge mclk) disable iff (rst)
        (is_idle && !op_in_rng) |=> is_idle)
        else $error("out-of-range operation started");
    a_addr_lock: assert property (@(posedge mclk) disable iff (rst)
        (!is_idle && !$past(is_idle)) |-> $stable(op_addr))
        else $error("address changed while busy");
    a_idx_wr_void: assert property (@(posedge mclk) disable iff (rst)
        (win_q && external_move_instruction.valid && external_move_instruction.write && !external_move_instruction.via_data_pointer_16bit)
        |-> !ext_wr && !xram_wr)
        else $error("index write escaped window");
    a_ext_default: assert property (@(posedge mclk) disable iff (rst)
        (external_move_instruction.valid && !win_q && !xram_en_q) |-> (ext_rd || ext_wr))
        else $error("move not routed external");
    a_busy_rinvalid: assert property (@(posedge mclk) disable iff (rst)
        (!is_idle && dst == dfx_pkg::DFX_DST_FLASH) |=> !flash_rvalid)
        else $error("flash read valid while busy");
    a_lock_block: assert property (@(posedge mclk) disable iff (rst)
        !lock_n |-> !prg_grant)
        else $error("programmer granted while locked");

    c_erase: cover property (@(posedge mclk) disable iff (rst) fin_er);
    c_prog: cover property (@(posedge mclk) disable iff (rst) fin_pg);
    c_wake: cover property (@(posedge mclk) disable iff (rst) wake);
    c_flash_rd: cover property (@(posedge mclk) disable iff (rst) flash_rvalid);

endmodule

/* test/dfx_core_model.sv */
// dfx_core_model: core-side driver for register and external-move accesses
`timescale 1ns/10ps
module dfx_core_model (
    input  wire logic              mclk,        // system clock
    output logic      [3:0]        reg_addr,    // register address
    output logic      [7:0]        reg_wdata,   // register write data
    output logic                   reg_wr,      // write strobe
    output logic                   reg_rd,      // read strobe
    input  wire logic [7:0]        reg_rdata,   // register read data
    output dfx_pkg::dfx_external_move_instruction_s     external_move_instruction,        // move request
    input  wire dfx_pkg::dfx_dst_e external_move_instruction_dst,    // move routing
    input  wire logic [7:0]        flash_rdata, // flash read data
    input  wire logic              flash_rvalid // flash read data valid
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        external_move_instruction = '0;
    end

    // data are inverted and strobes dropped on release so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic mv(input logic w, p, input logic [15:0] dp, input logic [7:0] ix,
                      output dfx_pkg::dfx_dst_e dst, output logic [15:0] fd);
        @(posedge mclk);
        external_move_instruction <= '{1'b1, w, p, dp, ix, 8'h5A};
        #1;
        dst = external_move_instruction_dst;
        @(posedge mclk);
        external_move_instruction.valid <= 1'b0;
        external_move_instruction.data_pointer_16bit <= ~dp;
        #1;
        fd = {7'h00, flash_rvalid, flash_rdata};
    endtask
endmodule

/* test/dfx_ctrl_tb.sv */
// dfx_ctrl_tb: self-checking bench for the data flash and move window controller
`timescale 1ns/10ps
module dfx_ctrl_tb;
    localparam int EC = 20;
    localparam int PC = 10;
    logic mclk, rst, lock_n, prg_req, global_ie, idle, reg_wr, reg_rd;
    logic prg_grant, irq, wake, osc_en, busy, cpu_stall, flash_rvalid;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, flash_rdata;
    logic [15:0] bcnt, ocnt, wakes, stalls;
    logic ext_rd, ext_wr, xram_rd, xram_wr;
    logic [3:0] stb;
    logic [15:0] external_move_instruction_addr, madr;
    dfx_pkg::dfx_external_move_instruction_s external_move_instruction;
    dfx_pkg::dfx_dst_e external_move_instruction_dst;
    int miscompares = 0;
    int cmp_count = 0;

    dfx_core_model dfx_core_model_i (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_move_instruction(external_move_instruction), .external_move_instruction_dst(external_move_instruction_dst),
        .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
    dfx_ctrl #(.ERASE_CYC(EC), .PROG_CYC(PC)) dfx_ctrl_i (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_move_instruction(external_move_instruction),
        .external_move_instruction_dst(external_move_instruction_dst), .external_move_instruction_addr(external_move_instruction_addr), .ext_rd(ext_rd), .ext_wr(ext_wr),
        .xram_rd(xram_rd), .xram_wr(xram_wr),
        .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
        .lock_n(lock_n), .prg_req(prg_req), .prg_grant(prg_grant),
        .global_ie(global_ie), .idle(idle), .irq(irq), .wake(wake),
        .osc_en(osc_en), .busy(busy), .cpu_stall(cpu_stall));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        bcnt <= bcnt + {15'h0000, busy === 1'b1};
        ocnt <= ocnt + {15'h0000, osc_en === 1'b1};
        wakes <= wakes + {15'h0000, wake === 1'b1};
        stalls <= stalls + {15'h0000, cpu_stall !== 1'b0};
        // strobes and address are taken at the edge where the move stands
        if (external_move_instruction.valid === 1'b1) begin
            stb <= {ext_rd, ext_wr, xram_rd, xram_wr};
            madr <= external_move_instruction_addr;
        end
    end

    // ************************************************************
    // access and compare tasks
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic chk_dst(input dfx_pkg::dfx_dst_e got, input dfx_pkg::dfx_dst_e exp);
        chk({14'h0000, got}, {14'h0000, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        dfx_core_model_i.wr(a, d);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] r;
        dfx_core_model_i.rd(a, r);
        chk({8'h00, r}, {8'h00, e});
    endtask
    task automatic route(input logic w, p, input logic [15:0] dp, input dfx_pkg::dfx_dst_e e);
        dfx_pkg::dfx_dst_e d;
        logic [15:0] fd;
        logic x, s;
        x = (e == dfx_pkg::DFX_DST_EXT);
        s = (e == dfx_pkg::DFX_DST_XRAM);
        dfx_core_model_i.mv(w, p, dp, 8'hC5, d, fd);
        chk_dst(d, e);
        chk({12'h000, stb}, {12'h000, x && !w, x && w, s && !w, s && w});
        // index moves here run with the page-high byte still at its reset value
        chk(madr, p ? dp : 16'h00C5);
    endtask
    task automatic fread(input logic p, input logic [15:0] dp, input logic [7:0] ix,
                         input logic [15:0] e);
        dfx_pkg::dfx_dst_e d;
        logic [15:0] fd;
        dfx_core_model_i.mv(1'b0, p, dp, ix, d, fd);
        chk(e[8] ? fd : (fd & 16'h0100), e);
    endtask
    // counters restart just after the edge that takes the control write
    task automatic go(input logic [7:0] v);
        wr(dfx_pkg::OFS_CTRL, v);
        #1;
        bcnt = 16'h0000;
        ocnt = 16'h0000;
        wakes = 16'h0000;
    endtask
    task automatic op();
        int i;
        i = 0;
        @(posedge mclk);
        #1;
        while (busy !== 1'b0 && i < 300) begin
            @(posedge mclk);
            #1;
            i++;
        end
        if (i >= 300) begin
            miscompares++;
            $display("FAIL %0t operation never finished", $time);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        lock_n = 1'b1;
        prg_req = 1'b0;
        global_ie = 1'b0;
        idle = 1'b0;
        stalls = 16'h0000;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rchk(dfx_pkg::OFS_CTRL, 8'h00);
        rchk(dfx_pkg::OFS_STATUS, 8'h00);
        route(1'b0, 1'b1, 16'h0100, dfx_pkg::DFX_DST_EXT);
        route(1'b1, 1'b1, 16'h0100, dfx_pkg::DFX_DST_EXT);
        wr(dfx_pkg::OFS_PMC, 8'h01);
        route(1'b0, 1'b1, 16'h07FF, dfx_pkg::DFX_DST_XRAM);
        route(1'b1, 1'b1, 16'h0000, dfx_pkg::DFX_DST_XRAM);
        wr(dfx_pkg::OFS_CTRL, 8'h20);
        route(1'b0, 1'b1, 16'h07FF, dfx_pkg::DFX_DST_FLASH);
        route(1'b0, 1'b1, 16'h0800, dfx_pkg::DFX_DST_EXT);
        route(1'b1, 1'b1, 16'h0100, dfx_pkg::DFX_DST_NONE);
        route(1'b1, 1'b1, 16'h2000, dfx_pkg::DFX_DST_EXT);
        route(1'b1, 1'b0, 16'h2000, dfx_pkg::DFX_DST_NONE);
        wr(dfx_pkg::OFS_IRQ_EN, 8'h20);
        global_ie <= 1'b1;
        idle <= 1'b1;
        wr(dfx_pkg::OFS_ADDR_HI, 8'h10);
        wr(dfx_pkg::OFS_ADDR_LO, 8'h00);
        go(8'hA0);
        op();
        chk(bcnt, 16'h0000);
        wr(dfx_pkg::OFS_ADDR_HI, 8'h07);
        wr(dfx_pkg::OFS_ADDR_LO, 8'hF0);
        go(8'hA0);
        op();
        chk(bcnt, 16'(EC));
        chk(ocnt, 16'(EC));
        chk_bit(irq, 1'b1);
        rchk(dfx_pkg::OFS_CTRL, 8'h21);
        chk(wakes, 16'h0001);
        go(8'h61);
        op();
        chk(bcnt, 16'h0000);
        wr(dfx_pkg::OFS_CTRL, 8'h20);
        #1;
        chk_bit(irq, 1'b0);
        fread(1'b1, 16'h07F5, 8'h00, 16'h01FF);
        wr(dfx_pkg::OFS_ADDR_LO, 8'hC5);
        wr(dfx_pkg::OFS_WDATA, 8'hA5);
        go(8'h60);
        wr(dfx_pkg::OFS_ADDR_LO, 8'h33);
        wr(dfx_pkg::OFS_WDATA, 8'h0F);
        wr(dfx_pkg::OFS_CTRL, 8'hA0);
        fread(1'b1, 16'h07C5, 8'h00, 16'h0000);
        op();
        chk(bcnt, 16'(PC));
        chk(stalls, 16'h0000);
        rchk(dfx_pkg::OFS_ADDR_LO, 8'hC5);
        rchk(dfx_pkg::OFS_WDATA, 8'hA5);
        wr(dfx_pkg::OFS_PAGE_HI, 8'h07);
        fread(1'b0, 16'h0000, 8'hC5, 16'h01A5);
        fread(1'b1, 16'h07C6, 8'h00, 16'h01FF);
        @(posedge mclk);
        lock_n <= 1'b0;
        prg_req <= 1'b1;
        @(posedge mclk);
        #1;
        chk_bit(prg_grant, 1'b0);
        @(posedge mclk);
        lock_n <= 1'b1;
        @(posedge mclk);
        #1;
        chk_bit(prg_grant, 1'b1);
        wr(dfx_pkg::OFS_CTRL, 8'h20);
        go(8'hA0);
        repeat (3) @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk_bit(osc_en, 1'b0);
        chk_bit(busy, 1'b0);
        rchk(dfx_pkg::OFS_CTRL, 8'h00);
        print_verdict();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #300_000;
        miscompares++;
        print_verdict();
    end
endmodule
